// ==== verilog/replay_double_buffer_fifo.sv ====
// Replay memory with two alternating hardware buffers for an 8-bit generator.
// Assumes host writes arrive synchronous to sys_clk and converters take ready/valid.
`timescale 1ns/10ps
`default_nettype none
module replay_double_buffer_fifo #(
   parameter int ADDR_WIDTH = replay_pkg::ADDR_WIDTH
) (
   input  wire logic                                sys_clk,
   input  wire logic                                rst,
   input  wire logic                                host_write_valid,
   input  wire replay_pkg::host_write_type          host_write,
   input  wire logic                                cmd_valid,
   input  wire logic [7:0]                          cmd_code,
   input  wire logic                                fifo_mode,
   input  wire logic [ADDR_WIDTH-1:0]               buffer_len,
   input  wire replay_pkg::chan_count_type          chan_count,
   input  wire logic [3:0]                          rate_divider,
   input  wire logic                                ext_trigger,
   input  wire logic                                soft_trigger,
   input  wire logic                                gate,
   input  wire logic                                segment_end,
   input  wire logic                                refill_done,
   output logic                                     buffer_empty_irq,
   output logic                                     underrun,
   output logic                                     running,
   output logic                                     triggered,
   output logic                                     active_buffer,
   output logic                                     out_valid,
   input  wire logic                                out_ready,
   output replay_pkg::sample_pair_type              converter_input_bits
);

   localparam int DEPTH = 1 << ADDR_WIDTH;

   // Limits a user must know:
   // - buffer_len counts memory words, so shared channels halve the steps per buffer
   // - with shared channels a buffer_len of 1 still takes one full word pair
   // - buffer_len and rate_divider are taken at start only; fifo_mode is used live throughout the run
   // - refill_done marks the buffer that holds the current write position

   // Replay memory: one word array per memory channel
   logic [replay_pkg::WORD_WIDTH-1:0] mem [replay_pkg::MEM_CHANNELS][DEPTH];

   replay_pkg::run_state_type state;
   logic [ADDR_WIDTH-1:0]     rd_ptr;
   logic [ADDR_WIDTH-1:0]     half_len;
   logic [1:0]                buf_full;
   logic [3:0]                eff_div;
   logic [3:0]                div_count;
   logic                      buf_in_ready;
   logic                      buf_out_valid;
   logic [2*replay_pkg::SAMPLE_WIDTH-1:0] buf_out_data;
   replay_pkg::run_state_type next_state;

   // Write address: position in samples, low bits only
   wire [ADDR_WIDTH-1:0] wr_addr = host_write.position[ADDR_WIDTH-1:0];
   wire                  wr_half = wr_addr >= half_len;

   // Rate cap: minimum divider per channel count keeps 250 MB/s
   wire [3:0] min_div = (chan_count == replay_pkg::CH_ONE)  ? 4'h0 :
                        (chan_count == replay_pkg::CH_TWO)  ? 4'h1 :
                        (chan_count == replay_pkg::CH_FOUR) ? 4'h3 : 4'h7;
   wire [3:0] cap_div = (rate_divider < min_div) ? min_div : rate_divider;

   // Command decode
   wire start_cmd = cmd_valid && (cmd_code == replay_pkg::CMD_START);
   wire halt_cmd  = cmd_valid && (cmd_code == replay_pkg::CMD_HALT);
   wire trig_hit  = ext_trigger || soft_trigger;

   // Buffer sizing: clamp to half the memory
   wire [ADDR_WIDTH-1:0] half_max = ADDR_WIDTH'(DEPTH / 2);
   wire [ADDR_WIDTH-1:0] len_clamp =
      (buffer_len == '0 || buffer_len > half_max) ? half_max : buffer_len;

   // Replay pacing: gate and segment options pause output
   wire tick     = (div_count == '0) && gate && !segment_end;
   wire step     = (state == replay_pkg::ST_RUN) && tick && buf_in_ready;
   wire [ADDR_WIDTH-1:0] buf_base = active_buffer ? half_len : '0;
   wire [ADDR_WIDTH-1:0] rd_addr  = buf_base + rd_ptr;
   wire dry       = fifo_mode && !buf_full[active_buffer];

   // Shared memory: one step takes a word pair, so a buffer holds half the steps
   wire multiplexed = chan_count != replay_pkg::CH_ONE;
   wire [ADDR_WIDTH-1:0] pair_steps = (half_len > ADDR_WIDTH'(1)) ? (half_len >> 1) :
                                      ADDR_WIDTH'(1);
   wire [ADDR_WIDTH-1:0] step_len  = multiplexed ? pair_steps : half_len;
   wire last_word = rd_ptr == (step_len - ADDR_WIDTH'(1));

   // Sample fetch: shared channels alternate A/B in memory 0, else A on 0, B on 1
   wire [ADDR_WIDTH-1:0] pair_addr = buf_base + {rd_ptr[ADDR_WIDTH-2:0], 1'b0};
   wire [replay_pkg::WORD_WIDTH-1:0] word_a = multiplexed ? mem[0][pair_addr] : mem[0][rd_addr];
   wire [replay_pkg::WORD_WIDTH-1:0] word_b =
      multiplexed ? mem[0][pair_addr | ADDR_WIDTH'(1)] : mem[1][rd_addr];
   // Low byte is the two's complement sample, D7 to MSB
   wire [2*replay_pkg::SAMPLE_WIDTH-1:0] fetch =
      {word_a[replay_pkg::SAMPLE_WIDTH-1:0], word_b[replay_pkg::SAMPLE_WIDTH-1:0]};

   // Host memory writes, sample addressed
   always_ff @(posedge sys_clk) begin
      if (host_write_valid) mem[host_write.mem_channel][wr_addr] <= host_write.data;
   end

   // Run decode: start only from idle, trigger only while armed
   wire start_ok  = start_cmd && (state == replay_pkg::ST_IDLE);
   wire trig_ok   = trig_hit && (state == replay_pkg::ST_ARMED);
   wire dry_step  = step && dry;
   wire live_step = step && !dry;
   wire wrap_step = live_step && last_word;

   // Next values of the run registers
   wire                  next_running   = start_ok ? 1'b1 : (dry_step ? 1'b0 : running);
   wire                  next_triggered = trig_ok ? 1'b1 : (dry_step ? 1'b0 : triggered);
   wire                  next_underrun  = start_ok ? 1'b0 : (dry_step ? 1'b1 : underrun);
   wire [ADDR_WIDTH-1:0] next_rd_ptr    = (start_ok || wrap_step) ? '0 :
                                          (live_step ? rd_ptr + ADDR_WIDTH'(1) : rd_ptr);
   wire                  next_active    = start_ok ? 1'b0 :
                                          (wrap_step ? ~active_buffer : active_buffer);
   wire [ADDR_WIDTH-1:0] next_half_len  = start_ok ? (fifo_mode ? len_clamp : half_max) :
                                          half_len;
   wire [3:0]            next_eff_div   = start_ok ? cap_div : eff_div;

   // Next run state; an illegal code falls back to idle
   always_comb begin
      next_state = state;
      unique case (state)
         replay_pkg::ST_IDLE: begin
            if (start_cmd) next_state = replay_pkg::ST_ARMED;
         end
         replay_pkg::ST_ARMED: begin
            if (trig_hit) next_state = replay_pkg::ST_RUN;
         end
         replay_pkg::ST_RUN: begin
            if (dry_step) next_state = replay_pkg::ST_IDLE;
         end
         default: begin
            next_state = replay_pkg::ST_IDLE;
         end
      endcase
   end

   // Run state; halt stops from any state
   always_ff @(posedge sys_clk) begin
      if (rst || halt_cmd) begin
         state <= replay_pkg::ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Running flag, from start until halt or underrun
   always_ff @(posedge sys_clk) begin
      if (rst || halt_cmd) begin
         running <= 1'b0;
      end else begin
         running <= next_running;
      end
   end

   // Trigger seen flag
   always_ff @(posedge sys_clk) begin
      if (rst || halt_cmd) begin
         triggered <= 1'b0;
      end else begin
         triggered <= next_triggered;
      end
   end

   // Underrun flag, kept until the next start or a halt
   always_ff @(posedge sys_clk) begin
      if (rst || halt_cmd) begin
         underrun <= 1'b0;
      end else begin
         underrun <= next_underrun;
      end
   end

   // Read pointer within the active buffer
   always_ff @(posedge sys_clk) begin
      if (rst || halt_cmd) begin
         rd_ptr <= '0;
      end else begin
         rd_ptr <= next_rd_ptr;
      end
   end

   // Active buffer, buffer zero first, flipped at its last word
   always_ff @(posedge sys_clk) begin
      if (rst || halt_cmd) begin
         active_buffer <= replay_pkg::RESET_BUFFER;
      end else begin
         active_buffer <= next_active;
      end
   end

   // Buffer length, latched at start
   always_ff @(posedge sys_clk) begin
      if (rst || halt_cmd) begin
         half_len <= half_max;
      end else begin
         half_len <= next_half_len;
      end
   end

   // Capped divider, latched at start
   always_ff @(posedge sys_clk) begin
      if (rst || halt_cmd) begin
         eff_div <= replay_pkg::RESET_DIVIDER;
      end else begin
         eff_div <= next_eff_div;
      end
   end

   // Rate divider counter
   always_ff @(posedge sys_clk) begin
      if (rst || state != replay_pkg::ST_RUN) begin
         div_count <= '0;
      end else begin
         div_count <= (div_count == '0) ? eff_div : div_count - 4'h1;
      end
   end

   // Buffer full flags: refill sets, exhaustion clears; set wins
   for (genvar b = 0; b < 2; b++) begin : g_full
      wire refill_hit = refill_done && (wr_half == 1'(b));
      wire drain_hit  = fifo_mode && step && last_word && (active_buffer == 1'(b));
      always_ff @(posedge sys_clk) begin
         if (rst || start_ok) begin
            buf_full[b] <= 1'b1;
         end else if (refill_hit) begin // Set wins over drain
            buf_full[b] <= 1'b1;
         end else if (drain_hit) begin
            buf_full[b] <= 1'b0;
         end
      end
   end

   // Empty-buffer interrupt pulse
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         buffer_empty_irq <= 1'b0;
      end else begin
         buffer_empty_irq <= step && last_word && fifo_mode && !dry;
      end
   end

   // Staging pops only when the output register takes the word
   wire stage_ready = !out_valid || out_ready;

   // Output staging so a converter stall loses no sample
   pair_buffer #(
      .WIDTH (2*replay_pkg::SAMPLE_WIDTH)
   ) u_pair_buffer (
      .sys_clk   (sys_clk),
      .rst       (rst || halt_cmd),
      .in_valid  (live_step),
      .in_ready  (buf_in_ready),
      .in_data   (fetch),
      .out_valid (buf_out_valid),
      .out_ready (stage_ready),
      .out_data  (buf_out_data)
   );

   // Registered converter outputs
   always_ff @(posedge sys_clk) begin
      if (rst || halt_cmd) begin
         out_valid            <= 1'b0;
         converter_input_bits <= '0;
      end else if (stage_ready) begin
         out_valid            <= buf_out_valid;
         converter_input_bits <= buf_out_data;
      end
   end

endmodule : replay_double_buffer_fifo
`default_nettype wire

// ==== verilog/replay_pkg.sv ====
// Package for the replay double-buffer block: constants, modes and carriers.
// Assumes one clock domain (sys_clk, 250 MHz) and synchronous active-high reset.
package replay_pkg;

   // Clock and rate figures
   localparam int CLOCK_MHZ           = 250;
   localparam int INTERNAL_MBPS       = 250;   // Internal byte throughput ceiling
   localparam int SAMPLE_BYTES        = 1;     // One byte per sample on the converter side

   // Widths
   localparam int POS_WIDTH           = 32;    // Start and length in samples
   localparam int WORD_WIDTH          = 16;    // Memory word
   localparam int SAMPLE_WIDTH        = 8;     // Converter sample
   localparam int ADDR_WIDTH          = 10;    // Default replay memory address width
   localparam int MEM_CHANNELS        = 2;     // Memory channels 0 and 1
   localparam int MAX_CHANNELS        = 8;

   // Command codes
   localparam logic [7:0] CMD_START   = 8'h0a; // Start code 10
   localparam logic [7:0] CMD_HALT    = 8'h14; // Halt code 20

   // Reset values
   localparam logic [1:0] RESET_CH_SEL   = 2'h0;
   localparam logic [3:0] RESET_DIVIDER  = 4'h0;
   localparam logic       RESET_BUFFER   = 1'b0;

   // Channel count selection: 1, 2, 4 or 8 channels
   typedef enum logic [1:0] {
      CH_ONE,
      CH_TWO,
      CH_FOUR,
      CH_EIGHT
   } chan_count_type;

   // Run state of the generator
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ARMED,
      ST_RUN
   } run_state_type;

   // Host memory write: position and data for one sample
   typedef struct packed {
      logic                     mem_channel;
      logic [POS_WIDTH-1:0]     position;
      logic [WORD_WIDTH-1:0]    data;
   } host_write_type;

   // Output sample pair toward converters
   typedef struct packed {
      logic [SAMPLE_WIDTH-1:0]  ch_a;
      logic [SAMPLE_WIDTH-1:0]  ch_b;
   } sample_pair_type;

endpackage : replay_pkg

// ==== verilog/pair_buffer.sv ====
// Two-entry buffer with valid/ready on both sides.
// Assumes a single clock and synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module pair_buffer #(
   parameter int WIDTH = 16
) (
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);

   logic [WIDTH-1:0] entry [2];
   logic             wr_ptr;
   logic             rd_ptr;
   logic [1:0]       count;

   // Handshake decode
   wire push = in_valid && in_ready;
   wire pop  = out_valid && out_ready;

   // Pointers and fill level
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wr_ptr    <= 1'b0;
         rd_ptr    <= 1'b0;
         count     <= 2'h0;
         in_ready  <= 1'b1;
         out_valid <= 1'b0;
      end else begin
         if (push) wr_ptr <= ~wr_ptr;
         if (pop) rd_ptr <= ~rd_ptr;
         count     <= count + {1'b0, push} - {1'b0, pop};
         in_ready  <= (count + {1'b0, push} - {1'b0, pop}) != 2'h2;
         out_valid <= (count + {1'b0, push} - {1'b0, pop}) != 2'h0;
      end
   end

   // Storage
   always_ff @(posedge sys_clk) begin
      if (push) entry[wr_ptr] <= in_data;
   end

   assign out_data = entry[rd_ptr];

endmodule : pair_buffer
`default_nettype wire

// ==== verification/replay_properties.sv ====
// Checker for the replay double-buffer block: commands, trigger, buffer events.
// Bound to every instance of the block; watches its ports only.
`timescale 1ns/10ps
`default_nettype none
module replay_properties (
   input wire logic                        sys_clk,
   input wire logic                        rst,
   input wire logic                        cmd_valid,
   input wire logic [7:0]                  cmd_code,
   input wire logic                        ext_trigger,
   input wire logic                        soft_trigger,
   input wire logic                        buffer_empty_irq,
   input wire logic                        underrun,
   input wire logic                        running,
   input wire logic                        triggered,
   input wire logic                        active_buffer,
   input wire logic                        out_valid,
   input wire logic                        out_ready,
   input wire replay_pkg::sample_pair_type converter_input_bits
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Command decodes
   wire is_start = cmd_valid && (cmd_code == replay_pkg::CMD_START);
   wire is_halt  = cmd_valid && (cmd_code == replay_pkg::CMD_HALT);
   wire any_trig = soft_trigger || ext_trigger;
   a_start_runs: assert property (is_start && !running |=> running)
      else $error("start left the block idle");
   a_halt_stops: assert property (is_halt |=> !running && !triggered)
      else $error("halt did not stop generation");
   a_trig_cause: assert property ($rose(triggered) |-> $past(any_trig) && running)
      else $error("trigger flag rose without a trigger");
   a_trig_prompt: assert property (running && !triggered && any_trig && !cmd_valid |=> triggered)
      else $error("trigger in armed state ignored");
   a_under_stops: assert property ($rose(underrun) |-> ##[0:2] !running)
      else $error("run continued after running dry");
   a_under_holds: assert property (underrun && !cmd_valid |=> underrun)
      else $error("underrun flag dropped on its own");
   a_irq_or_under: assert property (buffer_empty_irq |-> !underrun)
      else $error("refill request during underrun");
   a_first_buffer: assert property ($rose(running) |-> !active_buffer)
      else $error("replay did not begin in buffer zero");
   a_stall_keeps: assert property (out_valid && !out_ready && !cmd_valid
      |=> out_valid && $stable(converter_input_bits))
      else $error("stalled sample lost or changed");
   // Main scenarios reached
   c_trig: cover property ($rose(triggered));
   c_irq: cover property (buffer_empty_irq);
   c_under: cover property ($rose(underrun));
endmodule : replay_properties
bind replay_double_buffer_fifo replay_properties u_chk (.sys_clk, .rst, .cmd_valid,
   .cmd_code, .ext_trigger, .soft_trigger, .buffer_empty_irq, .underrun, .running,
   .triggered, .active_buffer, .out_valid, .out_ready, .converter_input_bits);
`default_nettype wire

// ==== verification/host_model.sv ====
// Host-side model: loads replay memory and refills each emptied buffer.
// Assumes the block's clock and LEN samples per hardware buffer.
`timescale 1ns/10ps
`default_nettype none
module host_model #(
   parameter int LEN = 8
) (
   input  wire logic                  sys_clk,
   input  wire logic                  buffer_empty_irq,
   input  wire logic                  hold_off,
   input  wire logic                  load_all,
   input  wire logic                  shared,
   output logic                       host_write_valid,
   output replay_pkg::host_write_type host_write,
   output logic                       refill_done
);
   int cnt = 0;
   int lim = 0;
   int base = 0;
   int pos;
   int idx;
   logic odd;
   logic nxt = 1'b0;
   logic [15:0] w;
   // Test pattern for a position: index high, inverse low
   function automatic logic [7:0] pat(input int p);
      return {p[3:0], ~p[3:0]};
   endfunction : pat
   // One word per falling edge; unshared, channel 0 then channel 1 per position, shared, channel 0 only
   always @(negedge sys_clk) begin
      if (load_all) begin // whole memory from position zero
         lim = shared ? 2 * LEN : 4 * LEN;
         base = 0;
         cnt = 0;
         nxt = 1'b0;
      end else if (buffer_empty_irq === 1'b1 && !hold_off) begin // buffers empty in turn
         lim = shared ? LEN : 2 * LEN;
         base = nxt ? LEN : 0;
         cnt = 0;
         nxt = ~nxt;
      end
      // Shared: positions scaled by two, A and B words interleaved
      pos = shared ? base + cnt : base + cnt / 2;
      idx = shared ? pos / 2 : pos;
      odd = shared ? pos[0] : cnt[0];
      w = odd ? {8'h00, ~pat(idx)} : {~pat(idx), pat(idx)};
      host_write_valid = cnt < lim;
      host_write.mem_channel = shared ? 1'b0 : cnt[0];
      host_write.position = 32'(pos); // counted in samples
      host_write.data = host_write_valid ? w : ~w;
      refill_done = host_write_valid && odd && (pos % LEN == LEN - 1);
      if (cnt < lim) cnt++;
   end
endmodule : host_model
`default_nettype wire

// ==== verification/tb_top.sv ====
// Testbench for the replay double-buffer block with a host model.
// Assumes a 250 MHz clock and a 16-word memory split into two buffers.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   localparam int AW = 4;
   logic sys_clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, fifo_mode = 1'b1, ext_trigger = 1'b0;
   logic soft_trigger = 1'b0, gate = 1'b1, segment_end = 1'b0, out_ready = 1'b1;
   logic hold_off = 1'b0, load_all = 1'b0, chk = 1'b0, shared = 1'b0;
   logic [7:0] cmd_code = 8'h00;
   logic [AW-1:0] buffer_len = 4'h0;
   logic [3:0] rate_divider = 4'h3; // 62.5 MS/s, inside the one-channel bus limit
   replay_pkg::chan_count_type chan_count = replay_pkg::CH_ONE;
   logic host_write_valid, refill_done, buffer_empty_irq, underrun, running, triggered;
   logic active_buffer, out_valid;
   replay_pkg::host_write_type host_write;
   replay_pkg::sample_pair_type converter_input_bits;
   int failures = 0, n_compared = 0, n_out = 0, n_irq = 0, cyc = 0, last_t = 0, gap = 0, c0;
   int span = 16; // Samples before the test pattern repeats
   replay_double_buffer_fifo #(.ADDR_WIDTH(AW)) DUT (.sys_clk, .rst, .host_write_valid,
      .host_write, .cmd_valid, .cmd_code, .fifo_mode, .buffer_len, .chan_count, .rate_divider,
      .ext_trigger, .soft_trigger, .gate, .segment_end, .refill_done, .buffer_empty_irq,
      .underrun, .running, .triggered, .active_buffer, .out_valid, .out_ready,
      .converter_input_bits);
   host_model #(.LEN(8)) u_host (.sys_clk, .buffer_empty_irq, .hold_off, .load_all, .shared,
      .host_write_valid, .host_write, .refill_done);
   // Clock and watchdog
   initial begin
      forever #2 sys_clk = ~sys_clk;
   end
   initial begin
      #40000;
      failures++;
      final_report();
   end
   function automatic logic [7:0] pat(input int p);
      return {p[3:0], ~p[3:0]};
   endfunction : pat
   // Accepted samples checked in order, refill requests counted
   always @(posedge sys_clk) begin
      cyc++;
      if (buffer_empty_irq === 1'b1) n_irq++;
      if (out_valid === 1'b1 && out_ready === 1'b1) begin
         if (chk) check(converter_input_bits.ch_a, pat(n_out % span));
         if (chk) check(converter_input_bits.ch_b, ~pat(n_out % span));
         gap = cyc - last_t;
         last_t = cyc;
         n_out++;
      end
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic cmd(input logic [7:0] c);
      @(negedge sys_clk) cmd_valid = 1'b1;
      cmd_code = c;
      @(negedge sys_clk) cmd_valid = 1'b0;
   endtask : cmd
   task automatic final_report;
      if (failures == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : final_report
   // Load, start, trigger, stream with stalls, pause, halt
   task automatic t_stream;
      load_all = 1'b1;
      repeat (2) @(negedge sys_clk);
      load_all = 1'b0;
      repeat (40) @(negedge sys_clk);
      chk = 1'b1;
      cmd(replay_pkg::CMD_START);
      check({7'h0, running}, 8'h01);
      repeat (8) @(negedge sys_clk);
      check(8'(n_out), 8'h00);
      soft_trigger = 1'b1;
      @(negedge sys_clk) soft_trigger = 1'b0;
      check({7'h0, triggered}, 8'h01);
      for (int i = 0; i < 300; i++) begin
         out_ready = (i % 7) != 3;
         @(negedge sys_clk);
      end
      out_ready = 1'b1;
      check({7'h0, n_irq > 3}, 8'h01);
      check({7'h0, underrun}, 8'h00);
      for (int k = 0; k < 2; k++) begin
         gate = k[0]; // Gate low, then segment_end high, each stops output
         segment_end = k[0];
         repeat (12) @(negedge sys_clk);
         c0 = n_out;
         repeat (24) @(negedge sys_clk);
         check(8'(n_out - c0), 8'h00);
      end
      gate = 1'b1;
      segment_end = 1'b0;
      c0 = n_out;
      repeat (80) @(negedge sys_clk);
      check({7'h0, n_out > c0 + 15}, 8'h01);
      cmd(replay_pkg::CMD_HALT);
      check({7'h0, running | triggered}, 8'h00);
      chk = 1'b0;
   endtask : t_stream
   // Two channels share memory 0 as interleaved words, double-buffered
   task automatic t_shared;
      shared = 1'b1;
      span = 8;
      chan_count = replay_pkg::CH_TWO;
      rate_divider = 4'h4; // 50 MS/s per channel
      load_all = 1'b1;
      repeat (2) @(negedge sys_clk);
      load_all = 1'b0;
      repeat (24) @(negedge sys_clk);
      n_out = 0;
      c0 = n_irq;
      chk = 1'b1;
      cmd(replay_pkg::CMD_START);
      soft_trigger = 1'b1;
      @(negedge sys_clk) soft_trigger = 1'b0;
      repeat (200) @(negedge sys_clk);
      check({7'h0, n_out > 30}, 8'h01);
      check({7'h0, n_irq - c0 > 5}, 8'h01);
      check({7'h0, underrun}, 8'h00);
      cmd(replay_pkg::CMD_HALT);
      check({7'h0, running}, 8'h00);
      chk = 1'b0;
      repeat (16) @(negedge sys_clk);
      shared = 1'b0;
      span = 16;
   endtask : t_shared
   // Host falls behind at eight channels; restart clears; halt while armed
   task automatic t_underrun;
      hold_off = 1'b1;
      buffer_len = 4'h8;
      chan_count = replay_pkg::CH_EIGHT;
      rate_divider = 4'h0;
      cmd(replay_pkg::CMD_START);
      ext_trigger = 1'b1;
      @(negedge sys_clk) ext_trigger = 1'b0;
      repeat (600) if (underrun !== 1'b1) @(negedge sys_clk);
      check({7'h0, underrun}, 8'h01);
      check({7'h0, running}, 8'h00);
      check(8'(gap), 8'h08);
      cmd(replay_pkg::CMD_START);
      check({7'h0, underrun}, 8'h00);
      cmd(replay_pkg::CMD_HALT);
      check({7'h0, running}, 8'h00);
   endtask : t_underrun
   // Main sequence
   initial begin
      repeat (16) @(negedge sys_clk);
      rst = 1'b0;
      check({4'h0, running, triggered, underrun, out_valid}, 8'h00);
      t_stream();
      t_shared();
      t_underrun();
      final_report();
   end
endmodule : tb_top
`default_nettype wire
